// >>> rtl/fsr_status.sv
// Status register pair of a serial flash, with its serial command front end
`timescale 1ns/1ns
`include "fsr_regs.svh"
module fsr_status (
   // System clock and reset
   input  wire logic                    clk_in,
   input  wire logic                    arst_n_in,
   // Serial link pins
   input  wire logic                    sck_in,
   input  wire logic                    cs_n_in,
   input  wire logic                    si_in,
   input  wire logic                    wp_n_in,
   output logic                         so_out,
   output logic                         so_oe_out,
   // Events and levels from the operation engines
   input  wire logic                    busy_in,
   input  wire logic                    program_suspended_in,
   input  wire logic                    erase_suspended_in,
   input  wire logic [`FSR_SECTORS-1:0] sector_protect_in,
   input  wire logic                    op_end_in,
   input  wire logic                    op_fail_in,
   input  wire logic                    op_abort_in,
   input  wire logic                    gated_end_in,
   input  wire logic                    hold_abort_in,
   input  wire logic                    freeze_done_in,
   // Controls to the operation engines
   output logic                         write_enable_latch_out,
   output logic                         protection_lock_out,
   output logic                         reset_cmd_enable_out,
   output logic                         lockdown_enable_out,
   output logic                         global_protect_out,
   output logic                         global_unprotect_out,
   output logic                         soft_reset_out,
   output logic [7:0]                   status_byte_one_out,
   output logic [7:0]                   status_byte_two_out
);

   fsr_pkg::fsr_core_t core_q;
   fsr_pkg::fsr_core_t core_d;
   fsr_pkg::fsr_link_t link_q;
   fsr_pkg::fsr_link_t link_d;
   logic               oe_q;
   logic               frame_end;
   logic               link_rst_n;
   logic               aligned;
   logic               full_op;
   logic               has_data;
   logic               pin_asserted;

   // Frame fields are quasi-static once chip select is high: no serial edges arrive
   assign frame_end    = core_q.cs_s2 & ~core_q.cs_prev;
   assign aligned      = (link_q.phase == 3'h0);
   assign full_op      = (link_q.nbytes != 2'h0);
   assign has_data     = link_q.nbytes[1];
   assign pin_asserted = ~core_q.wp_s2;
   // Frame state is wiped after the system side has taken it
   assign link_rst_n   = arst_n_in & ~core_q.frame_clr;

   // ---------------- System clock domain ----------------
   always_comb begin
      core_d             = core_q;
      core_d.cs_s1       = cs_n_in;
      core_d.cs_s2       = core_q.cs_s1;
      core_d.cs_prev     = core_q.cs_s2;
      core_d.wp_s1       = wp_n_in;
      core_d.wp_s2       = core_q.wp_s1;
      core_d.glob_prot   = 1'h0;
      core_d.glob_unprot = 1'h0;
      core_d.soft_rst    = 1'h0;
      core_d.frame_clr   = frame_end;
      core_d.busy        = busy_in;
      core_d.psus        = program_suspended_in;
      core_d.esus        = erase_suspended_in;
      // Continuous summary of the sector protection bits
      if (&sector_protect_in) begin
         core_d.software_protection_status = `FSR_SWP_ALL;
      end else if (|sector_protect_in) begin
         core_d.software_protection_status = `FSR_SWP_SOME;
      end else begin
         core_d.software_protection_status = `FSR_SWP_NONE;
      end
      // Clears from the engines come first so a same-cycle enable wins
      if (gated_end_in || hold_abort_in) begin
         core_d.write_enable_latch = 1'h0;
      end
      if (op_end_in && !op_abort_in) begin
         core_d.err = op_fail_in;
      end
      if (frame_end) begin
         case (link_q.op)
            `FSR_OP_WRITE_ENABLE: begin
               if (aligned && full_op) begin
                  core_d.write_enable_latch = 1'h1;
               end
            end
            `FSR_OP_WRITE_DISABLE: begin
               if (aligned && full_op) begin
                  core_d.write_enable_latch = 1'h0;
               end
            end
            `FSR_OP_WRITE_ONE: begin
               // Partial opcode never lands here: op stays clear
               if (full_op) begin
                  core_d.write_enable_latch = 1'h0;
               end
               if (core_q.write_enable_latch && aligned && has_data) begin
                  if (!(pin_asserted && core_q.lock && !link_q.dat[`FSR_B1_LOCK])) begin
                     core_d.lock = link_q.dat[`FSR_B1_LOCK];
                     if (!core_q.lock) begin
                        core_d.glob_prot = &link_q.dat[`FSR_GLOBAL_HI:`FSR_GLOBAL_LO];
                        core_d.glob_unprot = ~|link_q.dat[`FSR_GLOBAL_HI:`FSR_GLOBAL_LO];
                     end
                  end
               end
            end
            `FSR_OP_WRITE_TWO: begin
               if (full_op) begin
                  core_d.write_enable_latch = 1'h0;
               end
               if (core_q.write_enable_latch && aligned && has_data) begin
                  core_d.rst_en = link_q.dat[`FSR_B2_RST_EN];
                  if (!core_q.frozen) begin
                     core_d.lk_en = link_q.dat[`FSR_B2_LK_EN];
                  end
               end
            end
            `FSR_OP_SOFT_RESET: begin
               if (aligned && has_data && core_q.rst_en &&
                   link_q.dat == `FSR_RESET_CONFIRM) begin
                  core_d.soft_rst = 1'h1;
                  core_d.write_enable_latch      = 1'h0;
               end
            end
            default: begin
               core_d.write_enable_latch = core_d.write_enable_latch;
            end
         endcase
      end
      // Freeze is final and outranks any write in the same cycle
      if (freeze_done_in || core_q.frozen) begin
         core_d.frozen = 1'h1;
         core_d.lk_en  = 1'h0;
      end
      core_d.stat1 = {core_d.lock, 1'h0, core_d.err, core_q.wp_s2,
                      core_d.software_protection_status, core_d.write_enable_latch, core_d.busy};
      core_d.stat2 = {3'h0, core_d.rst_en, core_d.lk_en,
                      core_d.psus, core_d.esus, core_d.busy};
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         core_q       <= '0;
         core_q.cs_s1 <= 1'h1;
         core_q.cs_s2 <= 1'h1;
         core_q.cs_prev <= 1'h1;
         core_q.wp_s1 <= 1'h1;
         core_q.wp_s2 <= 1'h1;
         core_q.lock  <= `FSR_RST_BIT;
         core_q.write_enable_latch   <= `FSR_RST_BIT;
         core_q.rst_en <= `FSR_RST_BIT;
         core_q.lk_en <= `FSR_RST_BIT;
      end else begin
         core_q <= core_d;
      end
   end

   // ---------------- Serial clock domain ----------------
   always_comb begin
      link_d       = link_q;
      link_d.s1a   = core_q.stat1;
      link_d.s1b   = link_q.s1a;
      link_d.s2a   = core_q.stat2;
      link_d.s2b   = link_q.s2a;
      link_d.phase = link_q.phase + 3'h1;
      if (link_q.phase == 3'h7) begin
         link_d.sh = 7'h00;
         if (link_q.nbytes == 2'h0) begin
            link_d.op = {link_q.sh, si_in};
         end
         if (link_q.nbytes == 2'h1) begin
            link_d.dat = {link_q.sh, si_in};
         end
         if (link_q.nbytes != 2'h3) begin
            link_d.nbytes = link_q.nbytes + 2'h1;
         end
      end else begin
         link_d.sh = {link_q.sh[5:0], si_in};
      end
      // Bytes are refreshed at every boundary so a poll sees live status
      if (link_q.phase == 3'h7 && link_q.nbytes == 2'h0 &&
          {link_q.sh, si_in} == `FSR_OP_READ_STATUS) begin
         link_d.rd     = 1'h1;
         link_d.sel    = 1'h1;
         link_d.out_sh = link_q.s1b;
      end else if (link_q.rd) begin
         if (link_q.phase == 3'h7) begin
            link_d.out_sh = link_q.sel ? link_q.s2b : link_q.s1b;
            link_d.sel    = ~link_q.sel;
         end else begin
            link_d.out_sh = {link_q.out_sh[6:0], 1'h0};
         end
      end
   end

   always_ff @(posedge sck_in or negedge link_rst_n) begin
      if (!link_rst_n) begin
         link_q <= '0;
      end else begin
         link_q <= link_d;
      end
   end

   // Output enable drops at once when chip select rises
   always_ff @(posedge sck_in or posedge cs_n_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         oe_q <= 1'h0;
      end else if (cs_n_in) begin
         oe_q <= 1'h0;
      end else begin
         oe_q <= link_d.rd;
      end
   end

   assign so_out                 = link_q.out_sh[7];
   assign so_oe_out              = oe_q;
   assign write_enable_latch_out = core_q.write_enable_latch;
   assign protection_lock_out    = core_q.lock;
   assign reset_cmd_enable_out   = core_q.rst_en;
   assign lockdown_enable_out    = core_q.lk_en;
   assign global_protect_out     = core_q.glob_prot;
   assign global_unprotect_out   = core_q.glob_unprot;
   assign soft_reset_out         = core_q.soft_rst;
   assign status_byte_one_out    = core_q.stat1;
   assign status_byte_two_out    = core_q.stat2;

   // ---------------- Checks ----------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);

   a_rsvd_zero: assert property (core_q.stat2[7:5] == 3'h0)
      else $error("reserved status bits not zero");
   a_busy_mirror: assert property (##1 core_q.stat2[0] == $past(busy_in))
      else $error("busy bit does not follow busy input");
   a_rst_en_hold: assert property (!frame_end |=> $stable(core_q.rst_en))
      else $error("reset enable changed without a write");
   a_lk_en_hold: assert property (!frame_end |=> !$rose(core_q.lk_en))
      else $error("lockdown enable rose without a write");
   a_frozen_lk: assert property (freeze_done_in |=> !core_q.lk_en [*3])
      else $error("lockdown enable set after freeze");
   a_wel_gate: assert property (frame_end && !core_q.write_enable_latch |=>
         $stable(core_q.rst_en) && $stable(core_q.lock))
      else $error("status write took effect with latch clear");
   a_lock_pin: assert property (!core_q.wp_s2 && core_q.lock |=> core_q.lock)
      else $error("lock cleared while pin asserted");
   a_glob_lock: assert property ((core_q.glob_prot || core_q.glob_unprot) |-> !$past(core_q.lock))
      else $error("global protect while locked");
   a_err_abort: assert property (op_end_in && op_abort_in |=> $stable(core_q.err))
      else $error("error flag changed on abort");
   a_err_fail: assert property (op_end_in && !op_abort_in |=> core_q.err == $past(op_fail_in))
      else $error("error flag not refreshed");
   a_wel_hold: assert property (hold_abort_in && !frame_end |=> !core_q.write_enable_latch)
      else $error("latch not cleared by hold abort");
   a_soft_keep: assert property (core_q.soft_rst |-> !core_q.write_enable_latch &&
         core_q.lock == $past(core_q.lock))
      else $error("soft reset disturbed lock or latch");
   a_swp_code: assert property (##1 core_q.stat1[3:2] != 2'h2)
      else $error("reserved protection code");

   c_soft_reset: cover property (core_q.soft_rst);
   c_glob_prot: cover property (core_q.glob_prot);
   c_lock_set: cover property ($rose(core_q.lock));
   c_freeze: cover property (freeze_done_in ##1 core_q.frozen);

endmodule

// >>> rtl/fsr_regs.svh
// Constants for the flash status register block: opcodes, bit positions, reset values
`ifndef FSR_REGS_SVH
`define FSR_REGS_SVH

// Opcodes and the soft reset confirm data byte
`define FSR_OP_READ_STATUS   8'h05
`define FSR_OP_WRITE_ONE     8'h01
`define FSR_OP_WRITE_TWO     8'h31
`define FSR_OP_WRITE_ENABLE  8'h06
`define FSR_OP_WRITE_DISABLE 8'h04
`define FSR_OP_SOFT_RESET    8'hf0
`define FSR_RESET_CONFIRM    8'hd0

// Byte one positions
`define FSR_B1_LOCK      7
`define FSR_B1_ERROR     5
`define FSR_B1_PIN       4
`define FSR_B1_SWP_HI    3
`define FSR_B1_SWP_LO    2
`define FSR_B1_LATCH     1
`define FSR_B1_BUSY      0
// Global protect field within byte one write data
`define FSR_GLOBAL_HI    5
`define FSR_GLOBAL_LO    2

// Byte two positions
`define FSR_B2_RSVD_HI   7
`define FSR_B2_RSVD_LO   5
`define FSR_B2_RST_EN    4
`define FSR_B2_LK_EN     3
`define FSR_B2_PSUS      2
`define FSR_B2_ESUS      1
`define FSR_B2_BUSY      0

// Protection field codes
`define FSR_SWP_NONE     2'h0
`define FSR_SWP_SOME     2'h1
`define FSR_SWP_ALL      2'h3

// Reset values and sizes
`define FSR_RST_BIT      1'h0
`define FSR_RST_BYTE     8'h00
`define FSR_SECTORS      32

`endif

// >>> rtl/fsr_pkg.sv
// Types for the flash status register block
package fsr_pkg;

   // System clock domain state
   typedef struct packed {
      logic       cs_s1;
      logic       cs_s2;
      logic       cs_prev;
      logic       wp_s1;
      logic       wp_s2;
      logic       lock;
      logic       err;
      logic       write_enable_latch;
      logic       rst_en;
      logic       lk_en;
      logic       frozen;
      logic       busy;
      logic       psus;
      logic       esus;
      logic [1:0] software_protection_status;
      logic       glob_prot;
      logic       glob_unprot;
      logic       soft_rst;
      logic       frame_clr;
      logic [7:0] stat1;
      logic [7:0] stat2;
   } fsr_core_t;

   // Serial clock domain state
   typedef struct packed {
      logic [6:0] sh;
      logic [7:0] op;
      logic [7:0] dat;
      logic [2:0] phase;
      logic [1:0] nbytes;
      logic       rd;
      logic       sel;
      logic [7:0] out_sh;
      logic [7:0] s1a;
      logic [7:0] s1b;
      logic [7:0] s2a;
      logic [7:0] s2b;
   } fsr_link_t;

endpackage

// >>> testbench/fsr_host_model.sv
// Serial host model that frames commands on the status block's link pins
`timescale 1ns/1ns
module fsr_host_model (
   // Serial pins toward the block
   output logic      sck_out,
   output logic      cs_n_out,
   output logic      si_out,
   // Serial data back from the block
   input  wire logic so_in,
   input  wire logic so_oe_in
);
   initial begin
      sck_out = 1'b0;
      cs_n_out = 1'b1;
      si_out = 1'b0;
   end

   // Clock only runs inside a frame; mode 0, 64 ns period
   task automatic xfer(input logic [31:0] tx, input int nbits, output logic [23:0] rx);
      int i;
      rx = 24'h0;
      cs_n_out = 1'b0;
      for (i = 0; i < nbits; i++) begin
         si_out = tx[31-i];
         #32 sck_out = 1'b1;
         #32 sck_out = 1'b0;
         // Stream bits are taken half a period after the launching rise
         if (i >= 7 && so_oe_in === 1'b1) begin
            rx = {rx[22:0], so_in};
         end
      end
      #16 cs_n_out = 1'b1;
      // Released line must not keep showing the last bit
      si_out = ~si_out;
      // Gap well above the four system clocks that the block needs
      #200;
   endtask
endmodule

// >>> testbench/testbench.sv
// Self-checking bench for the flash status register block
`timescale 1ns/1ns
module testbench;
   logic        clk_in;
   logic        arst_n_in;
   logic        sck;
   logic        cs_n;
   logic        si;
   logic        so;
   logic        so_oe;
   logic        wp_n;
   logic        busy;
   logic        psus;
   logic        esus;
   logic [31:0] sectors;
   logic [5:0]  ev_q;
   logic        write_enable_latch;
   logic        lock;
   logic        rst_en;
   logic        lk_en;
   logic        g_prot;
   logic        g_unprot;
   logic        s_rst;
   logic [7:0]  b1;
   logic [7:0]  b2;
   logic [23:0] rx;
   int          mismatches;
   int          n_checks;
   int          n_glob;
   int          n_srst;
   int          n_unprot;
   int          cycles;

   initial begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end

   fsr_host_model host_u (.sck_out(sck), .cs_n_out(cs_n), .si_out(si), .so_in(so),
      .so_oe_in(so_oe));

   fsr_status dut_u (.clk_in(clk_in), .arst_n_in(arst_n_in), .sck_in(sck), .cs_n_in(cs_n),
      .si_in(si), .wp_n_in(wp_n), .so_out(so), .so_oe_out(so_oe), .busy_in(busy),
      .program_suspended_in(psus), .erase_suspended_in(esus), .sector_protect_in(sectors),
      .op_end_in(ev_q[0]), .op_fail_in(ev_q[1]), .op_abort_in(ev_q[2]),
      .gated_end_in(ev_q[3]), .hold_abort_in(ev_q[4]), .freeze_done_in(ev_q[5]),
      .write_enable_latch_out(write_enable_latch), .protection_lock_out(lock),
      .reset_cmd_enable_out(rst_en), .lockdown_enable_out(lk_en),
      .global_protect_out(g_prot), .global_unprotect_out(g_unprot), .soft_reset_out(s_rst),
      .status_byte_one_out(b1), .status_byte_two_out(b2));

   // Pulse counters, since the pulses last one cycle only
   always @(posedge clk_in) begin
      n_glob += (g_prot === 1'b1);
      n_srst += (s_rst === 1'b1);
      n_unprot += (g_unprot === 1'b1);
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic check(input string what, input logic [23:0] got, input logic [23:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk_in);
   endtask

   task automatic ev(input logic [5:0] v);
      @(posedge clk_in) ev_q <= v;
      @(posedge clk_in) ev_q <= 6'h00;
      idle(3);
   endtask

   task automatic wr(input logic [7:0] op, input logic [7:0] dat);
      host_u.xfer({op, dat, 16'h0000}, 16, rx);
   endtask

   task automatic en();
      host_u.xfer(32'h06000000, 8, rx);
   endtask

   initial begin
      arst_n_in = 1'b0;
      wp_n = 1'b1;
      busy = 1'b0;
      psus = 1'b0;
      esus = 1'b0;
      sectors = 32'h0;
      ev_q = 6'h00;
      mismatches = 0;
      n_checks = 0;
      n_glob = 0;
      n_srst = 0;
      n_unprot = 0;
      cycles = 0;
      idle(8);
      arst_n_in <= 1'b1;
      idle(6);
      check("byte one", b1, 8'h10);
      check("byte two", b2, 8'h00);
      host_u.xfer(32'h05000000, 31, rx);
      check("stream", rx, 24'h100010);
      wr(8'h31, 8'hff);
      check("byte two", b2, 8'h00);
      en();
      check("byte one", b1, 8'h12);
      host_u.xfer(32'h30000000, 4, rx);
      check("byte one", b1, 8'h12);
      wr(8'h31, 8'hff);
      check("byte two", b2, 8'h18);
      check("byte one", b1, 8'h10);
      @(posedge clk_in) {busy, psus, esus} <= 3'h7;
      idle(4);
      check("byte two", b2, 8'h1f);
      host_u.xfer(32'h05000000, 31, rx);
      check("stream", rx, 24'h111f11);
      @(posedge clk_in) {busy, psus, esus} <= 3'h0;
      sectors <= 32'h0000_0100;
      idle(4);
      check("byte one", b1, 8'h14);
      @(posedge clk_in) sectors <= 32'hffff_ffff;
      idle(4);
      check("byte one", b1, 8'h1c);
      @(posedge clk_in) sectors <= 32'h0;
      en();
      wr(8'h01, 8'h3c);
      check("global protect", n_glob, 1);
      en();
      wr(8'h01, 8'h63);
      check("byte one", b1, 8'h10);
      @(posedge clk_in) wp_n <= 1'b0;
      idle(4);
      check("byte one", b1, 8'h00);
      en();
      wr(8'h01, 8'h80);
      check("byte one", b1, 8'h80);
      check("global unprotect", n_unprot, 1);
      en();
      wr(8'h01, 8'hbc);
      check("global protect", n_glob, 1);
      en();
      wr(8'h01, 8'h00);
      check("byte one", b1, 8'h80);
      @(posedge clk_in) wp_n <= 1'b1;
      en();
      wr(8'h01, 8'h00);
      check("lock", lock, 1'b0);
      ev(6'h03);
      check("byte one", b1, 8'h30);
      ev(6'h07);
      check("byte one", b1, 8'h30);
      ev(6'h01);
      check("byte one", b1, 8'h10);
      ev(6'h07);
      check("byte one", b1, 8'h10);
      en();
      ev(6'h08);
      check("latch", write_enable_latch, 1'b0);
      en();
      ev(6'h10);
      check("latch", write_enable_latch, 1'b0);
      en();
      host_u.xfer(32'h04000000, 8, rx);
      check("latch", write_enable_latch, 1'b0);
      en();
      wr(8'h01, 8'h80);
      en();
      wr(8'hf0, 8'hd0);
      check("soft reset", n_srst, 1);
      check("byte one", b1, 8'h90);
      check("global unprotect", n_unprot, 2);
      check("byte two", b2, 8'h18);
      check("lockdown enable", lk_en, 1'b1);
      wr(8'hf0, 8'h00);
      check("soft reset", n_srst, 1);
      en();
      wr(8'h31, 8'h08);
      check("reset enable", rst_en, 1'b0);
      en();
      wr(8'hf0, 8'hd0);
      check("soft reset", n_srst, 1);
      check("latch", write_enable_latch, 1'b1);
      ev(6'h20);
      check("byte two", b2, 8'h00);
      en();
      wr(8'h31, 8'h08);
      check("byte two", b2, 8'h00);
      report_and_stop();
   end
endmodule
